// [core/amgc_pkg.sv]
package amgc_pkg;

  // Register byte addresses on the AHB-Lite slave.
  localparam logic [7:0] AMGC_CTRL_ADDR  = 8'h00;
  localparam logic [7:0] AMGC_CFG_ADDR   = 8'h04;
  localparam logic [7:0] AMGC_CHSEL_ADDR = 8'h08;
  localparam logic [7:0] AMGC_PAIR_ADDR  = 8'h0C;
  localparam logic [7:0] AMGC_STAT_ADDR  = 8'h10;

  // Field layout.
  localparam int AMGC_EN_BIT    = 7;
  localparam int AMGC_START_BIT = 4;
  localparam int AMGC_GAIN_W    = 3;
  localparam int AMGC_CHAN_W    = 4;
  localparam int AMGC_PAIR_W    = 4;
  localparam int AMGC_DATA_W    = 10;

  // Reset values.
  localparam logic [2:0] AMGC_GAIN_RST = 3'h0;
  localparam logic [3:0] AMGC_CHAN_RST = 4'h0;
  localparam logic [3:0] AMGC_PAIR_RST = 4'h0;

  // Decoded amplifier settings.
  typedef enum logic [2:0]
  {
    AMGC_G1,
    AMGC_G2,
    AMGC_G4,
    AMGC_G8,
    AMGC_G16,
    AMGC_GHALF
  } amgc_gain_e;

  // Converter timing: 100 ksps at 250 MHz.
  localparam int AMGC_RATE_KSPS   = 100;
  localparam int AMGC_CLK_MHZ     = 250;
  localparam int AMGC_CONV_CYCLES =
    (AMGC_CLK_MHZ * 1000) / AMGC_RATE_KSPS;

  // AHB-Lite codes.
  localparam logic [1:0] AMGC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] AMGC_HTRANS_SEQ    = 2'h3;

endpackage

// [core/amgc_gain_decode.sv]
`timescale 1ns/10ps
module amgc_gain_decode
  import amgc_pkg::*;
(
  // Field in.
  input  wire logic [AMGC_GAIN_W-1:0] gain_select_field,
  // Decoded gain out.
  output amgc_gain_e                  gain
);

  always_comb
  begin
    unique case (gain_select_field)
      3'h0:    gain = AMGC_G1;
      3'h1:    gain = AMGC_G2;
      3'h2:    gain = AMGC_G4;
      3'h3:    gain = AMGC_G8;
      3'h4,
      3'h5:    gain = AMGC_G16;
      default: gain = AMGC_GHALF;
    endcase
  end

endmodule

// [core/amgc_top.sv]
// What this block does
// - The converter, track-and-hold and amplifier run only while enabled.
// - With the enable bit clear the whole subsystem is held shut down.
// - The multiplexer offers eight external inputs and a temperature sensor.
// - Each adjacent input pair is single-ended or differential on its own.
// - Pair configuration may change at any time without a reset.
// - After reset every input pair is single-ended.
// - The amplifier gain follows the three-bit gain select field.
// - Gains of 0.5, 2, 4, 8 and 16 are offered besides unity.
// - Reset sets the gain select field to unity gain.
// - The temperature sensor passes through the amplifier at the set gain.
// - Results are 10-bit and conversions run at up to 100 ksps.
// - Gain codes 000,001,010,011,10x,11x give 1,2,4,8,16,0.5.
// - Pair bits 0 to 3 select differential pairs with the even input positive.
// - Channel codes 0000 to 0111 pick external inputs, 1xxx the sensor.
// - Differential results are delivered in two's complement.
`timescale 1ns/10ps
module amgc_top
  import amgc_pkg::*;
#(
  parameter int CONV_CYCLES = AMGC_CONV_CYCLES
)
(
  // Clock and reset.
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // AHB-Lite slave.
  input  wire logic                   hsel,
  input  wire logic [7:0]             haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Analog front-end controls.
  output logic                        analog_power_on,
  output logic                        analog_shutdown,
  output logic      [AMGC_CHAN_W-1:0] mux_pos_sel,
  output logic                        mux_neg_valid,
  output logic      [AMGC_CHAN_W-1:0] mux_neg_sel,
  output logic                        temp_sensor_sel,
  output amgc_gain_e                  amp_gain,
  output logic                        track_hold,
  // Successive approximation core.
  input  wire logic                   sar_compare,
  output logic      [AMGC_DATA_W-1:0] sar_trial,
  output logic      [AMGC_DATA_W-1:0] result_data,
  output logic                        result_diff,
  output logic                        conv_busy
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************

  logic                   wr_pend_r;
  logic [7:0]             addr_r;
  logic                   en_r;
  logic [AMGC_GAIN_W-1:0] gain_r;
  logic [AMGC_CHAN_W-1:0] chan_r;
  logic [AMGC_PAIR_W-1:0] pair_r;
  logic                   start_r;
  logic                   cmp_s1_r;
  logic                   cmp_s2_r;
  logic                   go;

  assign go = hsel && hready && (htrans == AMGC_HTRANS_NONSEQ ||
    htrans == AMGC_HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end
    else
    begin
      wr_pend_r <= go && hwrite;
      if (go)
      begin
        addr_r <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_r   <= 1'b0;
      gain_r <= AMGC_GAIN_RST;
      chan_r <= AMGC_CHAN_RST;
      pair_r <= AMGC_PAIR_RST;
    end
    else if (wr_pend_r)
    begin
      unique case (addr_r)
        AMGC_CTRL_ADDR:  en_r   <= hwdata[AMGC_EN_BIT];
        AMGC_CFG_ADDR:   gain_r <= hwdata[AMGC_GAIN_W-1:0];
        AMGC_CHSEL_ADDR: chan_r <= hwdata[AMGC_CHAN_W-1:0];
        AMGC_PAIR_ADDR:  pair_r <= hwdata[AMGC_PAIR_W-1:0];
        default:         ;
      endcase
    end
  end

  // A write of 1 to the start bit, with the enable bit also 1 in the same write, launches one conversion.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      start_r <= 1'b0;
    end
    else
    begin
      start_r <= wr_pend_r && addr_r == AMGC_CTRL_ADDR &&
        hwdata[AMGC_START_BIT] && hwdata[AMGC_EN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (go && !hwrite)
    begin
      unique case (haddr)
        AMGC_CTRL_ADDR:
          hrdata <= 32'({en_r, 2'b00, conv_busy, 4'h0});
        AMGC_CFG_ADDR:   hrdata <= 32'(gain_r);
        AMGC_CHSEL_ADDR: hrdata <= 32'(chan_r);
        AMGC_PAIR_ADDR:  hrdata <= 32'(pair_r);
        AMGC_STAT_ADDR:
          hrdata <= 32'({result_diff, 5'h00, result_data});
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Latched conversion settings
  // ****************************************************************

  logic [AMGC_CHAN_W-1:0] cv_chan_r;
  logic [AMGC_PAIR_W-1:0] cv_pair_r;
  logic [AMGC_GAIN_W-1:0] cv_gain_r;
  logic [1:0]             pair_idx;
  logic                   cv_diff;

  // Settings are captured only at a conversion start.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cv_chan_r <= AMGC_CHAN_RST;
      cv_pair_r <= AMGC_PAIR_RST;
      cv_gain_r <= AMGC_GAIN_RST;
    end
    else if (start_r && !conv_busy)
    begin
      cv_chan_r <= chan_r;
      cv_pair_r <= pair_r;
      cv_gain_r <= gain_r;
    end
  end

  assign pair_idx = cv_chan_r[2:1];
  assign cv_diff  = !cv_chan_r[AMGC_CHAN_W-1] && cv_pair_r[pair_idx];

  amgc_gain_decode u_gain
  (
    .gain_select_field (cv_gain_r),
    .gain              (amp_gain)
  );

  always_comb
  begin
    temp_sensor_sel = cv_chan_r[AMGC_CHAN_W-1];
    mux_pos_sel     = cv_chan_r;
    mux_neg_sel     = cv_chan_r;
    mux_neg_valid   = 1'b0;
    if (cv_diff)
    begin
      mux_pos_sel   = {1'b0, cv_chan_r[2:1], 1'b0};
      mux_neg_sel   = {1'b0, cv_chan_r[2:1], 1'b1};
      mux_neg_valid = 1'b1;
    end
  end

  assign analog_power_on = en_r;
  assign analog_shutdown = !en_r;

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************

  typedef enum logic [1:0]
  {
    AMGC_IDLE,
    AMGC_TRACK,
    AMGC_CONV
  } amgc_state_e;

  amgc_state_e            state_r;
  logic [15:0]            cnt_r;
  logic [3:0]             bit_r;
  logic [AMGC_DATA_W-1:0] acc_r;
  logic [15:0]            step_len;

  assign step_len = 16'(CONV_CYCLES / (AMGC_DATA_W + 1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
    end
    else
    begin
      cmp_s1_r <= sar_compare;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= AMGC_IDLE;
      cnt_r   <= 16'h0000;
      bit_r   <= 4'h0;
      acc_r   <= '0;
    end
    else if (!en_r)
    begin
      state_r <= AMGC_IDLE;
    end
    else
    begin
      unique case (state_r)
        AMGC_IDLE:
          if (start_r)
          begin
            state_r <= AMGC_TRACK;
            cnt_r   <= 16'h0000;
          end
        AMGC_TRACK:
          if (cnt_r == step_len - 16'h0001)
          begin
            state_r <= AMGC_CONV;
            cnt_r   <= 16'h0000;
            bit_r   <= 4'(AMGC_DATA_W - 1);
            acc_r   <= '0;
          end
          else
          begin
            cnt_r <= cnt_r + 16'h0001;
          end
        AMGC_CONV:
          if (cnt_r == step_len - 16'h0001)
          begin
            cnt_r <= 16'h0000;
            acc_r[bit_r] <= cmp_s2_r;
            if (bit_r == 4'h0)
            begin
              state_r <= AMGC_IDLE;
            end
            else
            begin
              bit_r <= bit_r - 4'h1;
            end
          end
          else
          begin
            cnt_r <= cnt_r + 16'h0001;
          end
      endcase
    end
  end

  always_comb
  begin
    sar_trial = acc_r;
    if (state_r == AMGC_CONV)
    begin
      sar_trial[bit_r] = 1'b1;
    end
  end

  assign conv_busy  = state_r != AMGC_IDLE;
  assign track_hold = en_r && state_r != AMGC_CONV;

  // Differential codes are offset binary from the core; flip the MSB.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      result_data <= '0;
      result_diff <= 1'b0;
    end
    else if (state_r == AMGC_CONV && bit_r == 4'h0 &&
      cnt_r == step_len - 16'h0001)
    begin
      result_diff <= cv_diff;
      result_data <= cv_diff ?
        {!acc_r[AMGC_DATA_W-1], acc_r[AMGC_DATA_W-2:1], cmp_s2_r} :
        {acc_r[AMGC_DATA_W-1:1], cmp_s2_r};
    end
  end

endmodule

// [testbench/amgc_asserts.sv]
`timescale 1ns/10ps
module amgc_asserts
  import amgc_pkg::*;
#(
  parameter int CONV_CYCLES = AMGC_CONV_CYCLES
)
(
  // Clock and reset.
  input wire logic                   hclk,
  input wire logic                   hresetn,
  // Front-end controls.
  input wire logic                   analog_power_on,
  input wire logic                   analog_shutdown,
  input wire logic [AMGC_CHAN_W-1:0] mux_pos_sel,
  input wire logic                   mux_neg_valid,
  input wire logic [AMGC_CHAN_W-1:0] mux_neg_sel,
  input wire logic                   temp_sensor_sel,
  input wire amgc_gain_e             amp_gain,
  input wire logic                   track_hold,
  // Results.
  input wire logic [AMGC_DATA_W-1:0] result_data,
  input wire logic                   result_diff,
  input wire logic                   conv_busy
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_shutdown_inverse: assert property (
    analog_shutdown != analog_power_on) else $error("shutdown mismatch");
  a_idle_when_off: assert property (
    !analog_power_on [*2] |-> !conv_busy && !track_hold)
    else $error("active while off");
  a_pair_even_pos: assert property (
    mux_neg_valid |-> !mux_pos_sel[0] &&
      mux_neg_sel == 4'(mux_pos_sel + 4'h1)) else $error("bad pair");
  a_temp_single: assert property (
    temp_sensor_sel |-> !mux_neg_valid) else $error("sensor paired");
  a_gain_legal: assert property (
    amp_gain <= AMGC_GHALF) else $error("illegal gain");
  a_settings_held: assert property (
    conv_busy && $past(conv_busy) |-> $stable(amp_gain) &&
      $stable(mux_pos_sel)) else $error("settings moved");
  a_conv_bounded: assert property (
    $rose(conv_busy) |-> ##[1:60] !conv_busy) else $error("conv hang");
  a_result_on_done: assert property (
    !$stable(result_data) |-> $fell(conv_busy)) else $error("stray result");

  c_conv: cover property ($rose(conv_busy));
  c_diff: cover property ($fell(conv_busy) && result_diff);
  c_temp: cover property (conv_busy && temp_sensor_sel);
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import amgc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sar_compare;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r;
  logic analog_power_on, analog_shutdown, mux_neg_valid, temp_sensor_sel;
  logic track_hold, result_diff, conv_busy;
  logic [3:0] mux_pos_sel, mux_neg_sel;
  logic [9:0] sar_trial, result_data;
  amgc_gain_e amp_gain;
  integer seed = 93;
  logic [9:0] vin = 10'h000;
  int err_count = 0, samples_checked = 0, cyc = 0;

  amgc_top #(.CONV_CYCLES(44)) i_amgc_top (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .analog_power_on(analog_power_on), .analog_shutdown(analog_shutdown),
    .mux_pos_sel(mux_pos_sel), .mux_neg_valid(mux_neg_valid),
    .mux_neg_sel(mux_neg_sel), .temp_sensor_sel(temp_sensor_sel),
    .amp_gain(amp_gain), .track_hold(track_hold), .sar_compare(sar_compare),
    .sar_trial(sar_trial), .result_data(result_data),
    .result_diff(result_diff), .conv_busy(conv_busy));

  initial
  begin
    hclk = 0;
    forever #2 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    // The analog side answers each trial code against a random input level.
    sar_compare <= (sar_trial <= vin);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Single AHB-Lite transfer; hready is the slave's own hreadyout.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= AMGC_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Core codes are offset binary; differential results are two's complement.
  function automatic logic [9:0] exp_result(input logic [9:0] v,
                                            input logic dif);
    return dif ? {~v[9], v[8:0]} : v;
  endfunction

  function automatic amgc_gain_e exp_gain(input logic [2:0] g);
    if (g[2])
      return g[1] ? AMGC_GHALF : AMGC_G16;
    return amgc_gain_e'(g);
  endfunction

  // Programs settings, starts one conversion and checks the routing.
  task automatic conv(input logic [2:0] g, input logic [3:0] c,
                      input logic [3:0] p);
    logic d;
    logic [9:0] e;
    int n;
    d = !c[3] && p[c[2:1]];
    vin <= 10'($random(seed));
    ahb(1, AMGC_CFG_ADDR, 32'({$random(seed), g}));
    ahb(1, AMGC_CHSEL_ADDR, 32'(c));
    ahb(1, AMGC_PAIR_ADDR, 32'(p));
    ahb(1, AMGC_CTRL_ADDR, 32'h0000_0090);
    for (n = 0; n < 10 && conv_busy !== 1'b1; n++) @(posedge hclk);
    chk(32'(amp_gain), 32'(exp_gain(g)));
    chk(32'(temp_sensor_sel), 32'(c[3]));
    chk(32'(mux_neg_valid), 32'(d));
    if (!c[3])
      chk(32'(mux_pos_sel), 32'(d ? {c[3:1], 1'b0} : c));
    if (d)
      chk(32'(mux_neg_sel), 32'({c[3:1], 1'b1}));
    ahb(1, AMGC_PAIR_ADDR, 32'(~p));
    chk(32'(mux_neg_valid), 32'(d));
    for (n = 0; n < 100 && conv_busy !== 1'b0; n++) @(posedge hclk);
    chk(32'(result_diff), 32'(d));
    e = exp_result(vin, d);
    chk(32'(result_data), 32'(e));
    chk(32'(track_hold), 1);
    ahb(0, AMGC_STAT_ADDR, 0);
    chk(32'(r[15]), 32'(d));
    chk(r, {16'h0000, d, 5'h00, e});
  endtask

  initial
  begin
    hresetn = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h2;
    hwdata = 0;
    sar_compare = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    chk(32'(analog_shutdown), 1);
    chk(32'(amp_gain), 32'(AMGC_G1));
    ahb(0, AMGC_CFG_ADDR, 0);
    chk(r, 0);
    ahb(0, AMGC_PAIR_ADDR, 0);
    chk(r, 0);
    ahb(0, AMGC_CHSEL_ADDR, 0);
    chk(r, 0);
    ahb(1, 8'h14, $random(seed));
    ahb(0, 8'h14, 0);
    chk(r, 0);
    for (int g = 0; g < 8; g++) conv(3'(g), 4'h8, 4'hF);
    repeat (16) conv($random(seed), $random(seed), $random(seed));
    hresetn <= 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    ahb(0, AMGC_PAIR_ADDR, 0);
    chk(r, 0);
    ahb(0, AMGC_CFG_ADDR, 0);
    chk(r, 0);
    ahb(1, AMGC_CTRL_ADDR, 32'h0000_0010);
    repeat (5) @(posedge hclk);
    chk(32'(conv_busy), 0);
    ahb(1, AMGC_CTRL_ADDR, 32'h0000_0090);
    ahb(1, AMGC_CTRL_ADDR, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    chk(32'(conv_busy), 0);
    chk(32'(track_hold), 0);
    chk(32'(analog_power_on), 0);
    finish_test();
  end
endmodule

bind amgc_top amgc_asserts #(.CONV_CYCLES(CONV_CYCLES)) i_amgc_asserts (
  .hclk(hclk), .hresetn(hresetn), .analog_power_on(analog_power_on),
  .analog_shutdown(analog_shutdown), .mux_pos_sel(mux_pos_sel),
  .mux_neg_valid(mux_neg_valid), .mux_neg_sel(mux_neg_sel),
  .temp_sensor_sel(temp_sensor_sel), .amp_gain(amp_gain),
  .track_hold(track_hold), .result_data(result_data),
  .result_diff(result_diff), .conv_busy(conv_busy));
